//--- amt_timer_map.svh
`ifndef AMT_TIMER_MAP_SVH
`define AMT_TIMER_MAP_SVH

// ---------------------------------------------------------------------
// Clock and timing.
// ---------------------------------------------------------------------
`define AMT_CLK_HZ 50000000
`define AMT_CLK_MHZ (`AMT_CLK_HZ / 1000000)
`define AMT_PWM_PERIOD_NS 6000
`define AMT_PWM_CYCLES (`AMT_PWM_PERIOD_NS * `AMT_CLK_MHZ / 1000)
`define AMT_PWM_DUTY_DIV 96
`define AMT_PWM_DUTY_CYCLES (`AMT_PWM_CYCLES / `AMT_PWM_DUTY_DIV)
`define AMT_FB_PERIOD_US 500
`define AMT_FB_CYCLES (`AMT_FB_PERIOD_US * `AMT_CLK_MHZ)
`define AMT_MS_CYCLES (`AMT_CLK_HZ / 1000)
`define AMT_WAKE_MS 250
`define AMT_BURST_MS 500
`define AMT_GAP_MS 1500
`define AMT_BATT_OFF_MS 59750
`define AMT_HORN_TEST_MS 3000

// ---------------------------------------------------------------------
// Register offsets.
// ---------------------------------------------------------------------
`define AMT_OFS_CTRL 8'h00
`define AMT_OFS_PWM_PERIOD 8'h04
`define AMT_OFS_PWM_DUTY 8'h08
`define AMT_OFS_FB_IVAL 8'h0c
`define AMT_OFS_HORN_IVAL 8'h10
`define AMT_OFS_HORN_MODE 8'h14
`define AMT_OFS_STATUS 8'h18
`define AMT_OFS_HORN_COUNT 8'h1c

// ---------------------------------------------------------------------
// Control bit positions and reset values.
// ---------------------------------------------------------------------
`define AMT_CTRL_PWM 0
`define AMT_CTRL_FB 1
`define AMT_CTRL_HORN 2
`define AMT_CTRL_WAKE 3
`define AMT_CTRL_RST 4'h0

`endif

//--- amt_pkg.sv
package amt_pkg;

	// Event pulses of all timer channels, high bit first in status.
	typedef struct packed {
		logic wake_interval_irq;
		logic horn_phase_irq;
		logic feedback_tick_irq;
		logic pwm_duty_irq;
		logic pwm_period_irq;
	} amt_irq_type;

	// Horn pattern selection, Gray coded.
	typedef enum logic [1:0] {
		AMT_HORN_OFF = 2'h0,
		AMT_HORN_SMOKE = 2'h1,
		AMT_HORN_BATTERY = 2'h3,
		AMT_HORN_TEST = 2'h2
	} amt_horn_mode_type;

	// Priority of the event raised in the same cycle.
	typedef enum logic [1:0] {
		AMT_PRIO_LOW = 2'h0,
		AMT_PRIO_LEVEL1 = 2'h1,
		AMT_PRIO_HIGH = 2'h3
	} amt_prio_type;

endpackage : amt_pkg

//--- amt_timer_unit.sv
`timescale 1ns/10ps
`include "amt_timer_map.svh"

module amt_timer_unit
	import amt_pkg::*;
#(
	parameter logic [15:0] PWM_CYCLES = 16'(`AMT_PWM_CYCLES),
	parameter logic [15:0] PWM_DUTY = 16'(`AMT_PWM_DUTY_CYCLES),
	parameter logic [15:0] FB_CYCLES = 16'(`AMT_FB_CYCLES),
	parameter logic [15:0] MS_CYCLES = 16'(`AMT_MS_CYCLES)
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output amt_irq_type irq_o,
	output amt_prio_type irq_prio_o,
	output logic pwm_o,
	output logic horn_o,
	output logic wake_o
);

	// -----------------------------------------------------------------
	// Declarations.
	// -----------------------------------------------------------------
	logic [3:0] ctrl_reg, ctrl_next;
	logic [3:0] run_d_reg, run_d_next;
	logic [15:0] per_reg, per_next;
	logic [15:0] duty_reg, duty_next;
	logic [15:0] fb_iv_reg, fb_iv_next;
	logic [15:0] horn_iv_reg, horn_iv_next;
	amt_horn_mode_type mode_reg, mode_next;
	logic [4:0] status_reg, status_next;
	logic [31:0] rdata_next;
	amt_irq_type irq_next;
	amt_prio_type prio_next;
	logic [15:0] pwm_cnt_reg, pwm_cnt_next;
	logic pwm_next;
	logic [15:0] fb_cnt_reg, fb_cnt_next;
	logic [15:0] ms_cnt_reg, ms_cnt_next;
	logic ms_tick;
	logic [15:0] horn_cnt_reg, horn_cnt_next;
	logic [2:0] phase_reg, phase_next;
	logic horn_next;
	logic [11:0] wake_cnt_reg, wake_cnt_next;
	logic wake_next;
	logic [3:0] start;
	logic wr_horn_iv;
	logic wr_fb_iv;
	logic ev_per, ev_duty, ev_fb, ev_horn, ev_wake;
	logic [19:0] ent_first, ent_cur, ent_nxt;

	// Horn phase table entry: {horn on, next phase, length in ms}.
	function automatic logic [19:0] phase_entry(
		input amt_horn_mode_type mode,
		input logic [2:0] phase
	);
		logic [19:0] e;
		e = {1'b0, 3'h0, 16'(`AMT_HORN_TEST_MS)};
		case (mode)
			AMT_HORN_SMOKE: begin
				// Three bursts, silences between, long gap at the end.
				case (phase)
					3'h0: e = {1'b1, 3'h1, 16'(`AMT_BURST_MS)};
					3'h1: e = {1'b0, 3'h2, 16'(`AMT_BURST_MS)};
					3'h2: e = {1'b1, 3'h3, 16'(`AMT_BURST_MS)};
					3'h3: e = {1'b0, 3'h4, 16'(`AMT_BURST_MS)};
					3'h4: e = {1'b1, 3'h5, 16'(`AMT_BURST_MS)};
					default: e = {1'b0, 3'h0, 16'(`AMT_GAP_MS)};
				endcase
			end
			AMT_HORN_BATTERY: begin
				// The silence is split in two to fit the 16-bit interval.
				case (phase)
					3'h0: e = {1'b1, 3'h1, 16'(`AMT_BURST_MS)};
					3'h1: e = {1'b0, 3'h2, 16'(`AMT_BATT_OFF_MS)};
					default: e = {1'b0, 3'h0, 16'(`AMT_BATT_OFF_MS)};
				endcase
			end
			AMT_HORN_TEST: begin
				// One burst, then the horn stays silent in phase 1.
				case (phase)
					3'h0: e = {1'b1, 3'h1, 16'(`AMT_HORN_TEST_MS)};
					default: e = {1'b0, 3'h1, 16'(`AMT_HORN_TEST_MS)};
				endcase
			end
			default: e = {1'b0, 3'h0, 16'(`AMT_HORN_TEST_MS)};
		endcase
		return e;
	endfunction : phase_entry

	// -----------------------------------------------------------------
	// Register bus.
	// -----------------------------------------------------------------

	// Start edges, one per control bit, and interval write strobes.
	assign start = ctrl_reg & ~run_d_reg;
	assign wr_fb_iv = wr_i && (addr_i == `AMT_OFS_FB_IVAL);
	assign wr_horn_iv = wr_i && (addr_i == `AMT_OFS_HORN_IVAL);

	// Register writes, sticky status and read data.
	always_comb begin
		ctrl_next = ctrl_reg;
		per_next = per_reg;
		duty_next = duty_reg;
		fb_iv_next = fb_iv_reg;
		horn_iv_next = horn_iv_reg;
		mode_next = mode_reg;
		run_d_next = ctrl_reg;
		status_next = status_reg;
		rdata_next = 32'h0;
		if (wr_i) begin
			case (addr_i)
				`AMT_OFS_CTRL: ctrl_next = wdata_i[3:0];
				`AMT_OFS_PWM_PERIOD: per_next = wdata_i[15:0];
				`AMT_OFS_PWM_DUTY: duty_next = wdata_i[15:0];
				`AMT_OFS_FB_IVAL: fb_iv_next = wdata_i[15:0];
				`AMT_OFS_HORN_IVAL: horn_iv_next = wdata_i[15:0];
				`AMT_OFS_HORN_MODE: begin
					mode_next = amt_horn_mode_type'(wdata_i[1:0]);
				end
				`AMT_OFS_STATUS: status_next = status_reg & ~wdata_i[4:0];
				default: status_next = status_reg;
			endcase
		end
		// A new event wins over a clear in the same cycle.
		status_next = status_next | irq_next;
		if (rd_i) begin
			case (addr_i)
				`AMT_OFS_CTRL: rdata_next = {28'h0, ctrl_reg};
				`AMT_OFS_PWM_PERIOD: rdata_next = {16'h0, per_reg};
				`AMT_OFS_PWM_DUTY: rdata_next = {16'h0, duty_reg};
				`AMT_OFS_FB_IVAL: rdata_next = {16'h0, fb_iv_reg};
				`AMT_OFS_HORN_IVAL: rdata_next = {16'h0, horn_iv_reg};
				`AMT_OFS_HORN_MODE: rdata_next = {30'h0, mode_reg};
				`AMT_OFS_STATUS: rdata_next = {27'h0, status_reg};
				`AMT_OFS_HORN_COUNT: rdata_next = {16'h0, horn_cnt_reg};
				default: rdata_next = 32'h0;
			endcase
		end
	end

	// Register bus state.
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			ctrl_reg <= `AMT_CTRL_RST;
			run_d_reg <= `AMT_CTRL_RST;
			per_reg <= PWM_CYCLES;
			duty_reg <= PWM_DUTY;
			fb_iv_reg <= FB_CYCLES;
			horn_iv_reg <= 16'(`AMT_HORN_TEST_MS);
			mode_reg <= AMT_HORN_OFF;
			status_reg <= 5'h0;
			rdata_o <= 32'h0;
		end else begin
			ctrl_reg <= ctrl_next;
			run_d_reg <= run_d_next;
			per_reg <= per_next;
			duty_reg <= duty_next;
			fb_iv_reg <= fb_iv_next;
			horn_iv_reg <= horn_iv_next;
			mode_reg <= mode_next;
			status_reg <= status_next;
			rdata_o <= rdata_next;
		end
	end

	// -----------------------------------------------------------------
	// PWM pair, channels 0 and 1.
	// -----------------------------------------------------------------

	// Master counts the period; slave output is high for the duty.
	always_comb begin
		pwm_cnt_next = 16'h0;
		ev_per = 1'b0;
		ev_duty = 1'b0;
		if (ctrl_reg[`AMT_CTRL_PWM]) begin
			if (pwm_cnt_reg == per_reg - 16'h1) begin
				pwm_cnt_next = 16'h0;
				ev_per = 1'b1;
			end else begin
				pwm_cnt_next = pwm_cnt_reg + 16'h1;
			end
			ev_duty = (duty_reg != 16'h0) &&
				(pwm_cnt_reg == duty_reg - 16'h1);
		end
		pwm_next = ctrl_next[`AMT_CTRL_PWM] &&
			(pwm_cnt_next < duty_reg);
	end

	// PWM state.
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			pwm_cnt_reg <= 16'h0;
			pwm_o <= 1'b0;
		end else begin
			pwm_cnt_reg <= pwm_cnt_next;
			pwm_o <= pwm_next;
		end
	end

	// -----------------------------------------------------------------
	// Feedback tick, channel 2.
	// -----------------------------------------------------------------

	// Down counter, reloaded at start, on expiry and on a new value.
	always_comb begin
		fb_cnt_next = 16'h0;
		ev_fb = 1'b0;
		if (ctrl_reg[`AMT_CTRL_FB]) begin
			if (start[`AMT_CTRL_FB]) begin
				fb_cnt_next = fb_iv_reg - 16'h1;
				ev_fb = 1'b1;
			end else if (wr_fb_iv) begin
				fb_cnt_next = wdata_i[15:0] - 16'h1;
			end else if (fb_cnt_reg == 16'h0) begin
				fb_cnt_next = fb_iv_reg - 16'h1;
				ev_fb = 1'b1;
			end else begin
				fb_cnt_next = fb_cnt_reg - 16'h1;
			end
		end
	end

	// Feedback tick state.
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			fb_cnt_reg <= 16'h0;
		end else begin
			fb_cnt_reg <= fb_cnt_next;
		end
	end

	// -----------------------------------------------------------------
	// Millisecond prescaler for channel 3 and the wake timer.
	// -----------------------------------------------------------------

	// Free running, so a first phase may start up to 1 ms short.
	always_comb begin
		ms_tick = (ms_cnt_reg == MS_CYCLES - 16'h1);
		ms_cnt_next = ms_tick ? 16'h0 : ms_cnt_reg + 16'h1;
	end

	// Prescaler state.
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			ms_cnt_reg <= 16'h0;
		end else begin
			ms_cnt_reg <= ms_cnt_next;
		end
	end

	// -----------------------------------------------------------------
	// Horn sequencer, channel 3.
	// -----------------------------------------------------------------

	// Table lookups for the first, current and following phase.
	assign ent_first = phase_entry(mode_reg, 3'h0);
	assign ent_cur = phase_entry(mode_reg, phase_reg);
	assign ent_nxt = phase_entry(mode_reg, ent_cur[18:16]);

	// Interval counter in ms; each phase loads its own length.
	always_comb begin
		horn_cnt_next = horn_cnt_reg;
		phase_next = phase_reg;
		horn_next = horn_o;
		ev_horn = 1'b0;
		if (!ctrl_reg[`AMT_CTRL_HORN]) begin
			horn_cnt_next = 16'h0;
			phase_next = 3'h0;
			horn_next = 1'b0;
		end else if (start[`AMT_CTRL_HORN]) begin
			ev_horn = 1'b1;
			phase_next = 3'h0;
			if (mode_reg == AMT_HORN_OFF) begin
				horn_cnt_next = horn_iv_reg - 16'h1;
				horn_next = 1'b0;
			end else begin
				horn_cnt_next = ent_first[15:0] - 16'h1;
				horn_next = ent_first[19];
			end
		end else if (wr_horn_iv) begin
			horn_cnt_next = wdata_i[15:0] - 16'h1;
		end else if (ms_tick) begin
			if (horn_cnt_reg == 16'h0) begin
				ev_horn = 1'b1;
				if (mode_reg == AMT_HORN_OFF) begin
					horn_cnt_next = horn_iv_reg - 16'h1;
					horn_next = 1'b0;
				end else begin
					phase_next = ent_cur[18:16];
					horn_cnt_next = ent_nxt[15:0] - 16'h1;
					horn_next = ent_nxt[19];
				end
			end else begin
				horn_cnt_next = horn_cnt_reg - 16'h1;
			end
		end
	end

	// Horn sequencer state.
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			horn_cnt_reg <= 16'h0;
			phase_reg <= 3'h0;
			horn_o <= 1'b0;
		end else begin
			horn_cnt_reg <= horn_cnt_next;
			phase_reg <= phase_next;
			horn_o <= horn_next;
		end
	end

	// -----------------------------------------------------------------
	// 12-bit wake interval timer.
	// -----------------------------------------------------------------

	// Counts ms ticks and reloads itself on every expiry.
	always_comb begin
		wake_cnt_next = wake_cnt_reg;
		ev_wake = 1'b0;
		if (!ctrl_reg[`AMT_CTRL_WAKE]) begin
			wake_cnt_next = 12'h0;
		end else if (start[`AMT_CTRL_WAKE]) begin
			wake_cnt_next = 12'(`AMT_WAKE_MS - 1);
		end else if (ms_tick) begin
			if (wake_cnt_reg == 12'h0) begin
				wake_cnt_next = 12'(`AMT_WAKE_MS - 1);
				ev_wake = 1'b1;
			end else begin
				wake_cnt_next = wake_cnt_reg - 12'h1;
			end
		end
		wake_next = ev_wake;
	end

	// Wake timer state.
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			wake_cnt_reg <= 12'h0;
			wake_o <= 1'b0;
		end else begin
			wake_cnt_reg <= wake_cnt_next;
			wake_o <= wake_next;
		end
	end

	// -----------------------------------------------------------------
	// Event outputs and priority.
	// -----------------------------------------------------------------

	// Gather events and rank the highest one raised this cycle.
	always_comb begin
		irq_next.pwm_period_irq = ev_per;
		irq_next.pwm_duty_irq = ev_duty;
		irq_next.feedback_tick_irq = ev_fb;
		irq_next.horn_phase_irq = ev_horn;
		irq_next.wake_interval_irq = ev_wake;
		if (ev_fb) begin
			prio_next = AMT_PRIO_HIGH;
		end else if (ev_horn) begin
			prio_next = AMT_PRIO_LEVEL1;
		end else begin
			prio_next = AMT_PRIO_LOW;
		end
	end

	// Event output state.
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			irq_o <= '0;
			irq_prio_o <= AMT_PRIO_LOW;
		end else begin
			irq_o <= irq_next;
			irq_prio_o <= prio_next;
		end
	end

endmodule : amt_timer_unit

//--- amt_timer_unit_assertions.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------------
// Port checker of the timer unit.
// ---------------------------------------------------------------------
module amt_timer_unit_checker
	import amt_pkg::*;
#(
	parameter logic [15:0] PWM_CYCLES = 16'h012c,
	parameter logic [15:0] PWM_DUTY = 16'h0003,
	parameter logic [15:0] FB_CYCLES = 16'h61a8,
	parameter logic [15:0] MS_CYCLES = 16'hc350
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire amt_irq_type irq_o,
	input wire amt_prio_type irq_prio_o,
	input wire logic pwm_o,
	input wire logic horn_o,
	input wire logic wake_o
);
	logic [15:0] per_cnt_reg;
	logic [15:0] per_cnt_next;
	logic seen_reg;
	logic seen_next;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	// Cycles since the last period event; a restart would break the count.
	always_comb begin
		per_cnt_next = per_cnt_reg + 16'h0001;
		seen_next = seen_reg;
		if (irq_o.pwm_period_irq) begin
			per_cnt_next = 16'h0000;
			seen_next = 1'b1;
		end
	end

	// Registers of the period counter.
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			per_cnt_reg <= 16'h0000;
			seen_reg <= 1'b0;
		end else begin
			per_cnt_reg <= per_cnt_next;
			seen_reg <= seen_next;
		end
	end

	// The slave output stays high for exactly three cycles, the reset duty count.
	sequence s_duty_high;
		pwm_o [*3] ##1 !pwm_o;
	endsequence

	// The slave output rises shortly after the period event.
	sequence s_pwm_start;
		##[0:2] $rose(pwm_o);
	endsequence

	a_period_len: assert property (
		irq_o.pwm_period_irq && seen_reg |->
			per_cnt_reg == PWM_CYCLES - 16'h0001)
		else $error("PWM period length wrong.");
	a_period_restart: assert property (
		irq_o.pwm_period_irq |-> s_pwm_start)
		else $error("Period did not restart the duty.");
	a_duty_width: assert property (
		$rose(pwm_o) |-> s_duty_high)
		else $error("Duty pulse width wrong.");
	a_duty_irq: assert property (
		$rose(pwm_o) |-> ##[1:4] irq_o.pwm_duty_irq)
		else $error("Duty event missing.");
	a_prio_high: assert property (
		irq_o.feedback_tick_irq |-> irq_prio_o == AMT_PRIO_HIGH)
		else $error("Feedback tick priority wrong.");
	a_prio_level1: assert property (
		irq_o.horn_phase_irq && !irq_o.feedback_tick_irq |->
			irq_prio_o == AMT_PRIO_LEVEL1)
		else $error("Horn phase priority wrong.");
	a_prio_low: assert property (
		irq_o != '0 && !irq_o.horn_phase_irq &&
			!irq_o.feedback_tick_irq |-> irq_prio_o == AMT_PRIO_LOW)
		else $error("Low priority wrong.");
	a_wake_pair: assert property (
		wake_o == irq_o.wake_interval_irq)
		else $error("Wake pulse and event differ.");
	a_wake_spacing: assert property (
		irq_o.wake_interval_irq |=> !irq_o.wake_interval_irq [*8])
		else $error("Wake events too close.");
	a_horn_single: assert property (
		irq_o.horn_phase_irq |=> !irq_o.horn_phase_irq)
		else $error("Horn event longer than one cycle.");
endmodule : amt_timer_unit_checker

bind amt_timer_unit amt_timer_unit_checker #(.PWM_CYCLES(PWM_CYCLES),
	.PWM_DUTY(PWM_DUTY), .FB_CYCLES(FB_CYCLES), .MS_CYCLES(MS_CYCLES))
	u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.irq_o(irq_o), .irq_prio_o(irq_prio_o), .pwm_o(pwm_o),
	.horn_o(horn_o), .wake_o(wake_o));

//--- amt_load_model.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------------
// Boost switch and horn driver load.
// ---------------------------------------------------------------------
module amt_load_model (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic pwm_i,
	input wire logic horn_i,
	output logic [15:0] pwm_width_o,
	output logic [31:0] horn_len_o
);
	logic [15:0] pwm_run_reg;
	logic [31:0] horn_run_reg;

	// The switch conducts while the drive is high; the horn sounds likewise.
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			pwm_run_reg <= 16'h0000;
			horn_run_reg <= 32'h0000_0000;
			pwm_width_o <= 16'h0000;
			horn_len_o <= 32'h0000_0000;
		end else begin
			if (pwm_i) begin
				pwm_run_reg <= pwm_run_reg + 16'h0001;
			end else begin
				if (pwm_run_reg != 16'h0000) begin
					pwm_width_o <= pwm_run_reg;
				end
				pwm_run_reg <= 16'h0000;
			end
			if (horn_i) begin
				horn_run_reg <= horn_run_reg + 32'h0000_0001;
			end else begin
				if (horn_run_reg != 32'h0000_0000) begin
					horn_len_o <= horn_run_reg;
				end
				horn_run_reg <= 32'h0000_0000;
			end
		end
	end
endmodule : amt_load_model

//--- amt_timer_unit_tb_top.sv
`timescale 1ns/10ps
`include "amt_timer_map.svh"

// ---------------------------------------------------------------------
// Testbench of the timer unit.
// ---------------------------------------------------------------------
module amt_timer_unit_tb_top
	import amt_pkg::*;
;
	localparam int MS = 1;
	logic ref_clk_i = 1'b0;
	logic rstn_i;
	logic [7:0] addr_i;
	logic [31:0] wdata_i;
	logic wr_i;
	logic rd_i;
	logic [31:0] rdata_o;
	amt_irq_type irq_o;
	amt_prio_type irq_prio_o;
	logic pwm_o;
	logic horn_o;
	logic wake_o;
	logic [4:0] irq_v;
	logic [15:0] pwm_width;
	logic [31:0] horn_len;
	logic [31:0] d;
	int n;
	int error_cnt = 0;
	int n_compared = 0;
	logic [31:0] rst_val [7] = '{32'h0, 32'h12c, 32'h3, 32'h61a8,
		32'hbb8, 32'h0, 32'h0};

	assign irq_v = irq_o;

	// Clock of 20 ns.
	always #10 ref_clk_i = ~ref_clk_i;

	amt_timer_unit #(.MS_CYCLES(16'h0001)) dut (.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.irq_prio_o(irq_prio_o), .pwm_o(pwm_o), .horn_o(horn_o),
		.wake_o(wake_o));

	amt_load_model u_load (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.pwm_i(pwm_o), .horn_i(horn_o), .pwm_width_o(pwm_width),
		.horn_len_o(horn_len));

	// Prints the verdict and stops the run.
	task automatic end_of_test();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	// Compares a seen value with the expected one.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One-cycle write strobe.
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : wr_reg

	// One-cycle read strobe; data taken in the following cycle.
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		v = rdata_o;
	endtask : rd_reg

	// Counts cycles until the chosen event, with a bound.
	task automatic wait_irq(input int idx, output int cnt);
		cnt = 0;
		do begin
			@(posedge ref_clk_i);
			#1;
			cnt++;
			if (cnt > 70000) begin
				error_cnt++;
				end_of_test();
			end
		end while (irq_v[idx] !== 1'b1);
	endtask : wait_irq

	// Stops channel 3, selects a pattern and starts it again.
	task automatic run_mode(input amt_horn_mode_type m);
		wr_reg(`AMT_OFS_CTRL, 32'h3);
		wr_reg(`AMT_OFS_HORN_MODE, 32'(m));
		wr_reg(`AMT_OFS_CTRL, 32'h7);
		@(posedge ref_clk_i);
		#1;
		check(irq_v[3], 1'b1);
		check(horn_o, 1'b1);
	endtask : run_mode

	// Main sequence.
	initial begin
		rstn_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		repeat (8) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		@(posedge ref_clk_i);
		#1;
		check({irq_v, pwm_o, horn_o, wake_o}, 32'h0);
		for (int i = 0; i < 7; i++) begin
			rd_reg(8'(i * 4), d);
			check(d, rst_val[i]);
		end
		wr_reg(8'h20, 32'hffff_ffff);
		rd_reg(8'h20, d);
		check(d, 32'h0);
		wr_reg(`AMT_OFS_CTRL, 32'h1);
		wait_irq(0, n);
		wait_irq(0, n);
		check(n, 300);
		check(pwm_width, 16'h0003);
		wait_irq(1, n);
		wait_irq(1, n);
		check(n, 300);
		wr_reg(`AMT_OFS_FB_IVAL, 32'h64);
		wr_reg(`AMT_OFS_CTRL, 32'h3);
		@(posedge ref_clk_i);
		#1;
		check(irq_v[2], 1'b1);
		wait_irq(2, n);
		check(n, 100);
		check(irq_prio_o, AMT_PRIO_HIGH);
		wr_reg(`AMT_OFS_HORN_IVAL, 32'h28);
		wr_reg(`AMT_OFS_CTRL, 32'h7);
		@(posedge ref_clk_i);
		#1;
		check(irq_v[3], 1'b1);
		wait_irq(3, n);
		wait_irq(3, n);
		check(n, 40 * MS);
		check(horn_o, 1'b0);
		run_mode(AMT_HORN_TEST);
		wait_irq(3, n);
		check(n >= 2999 * MS && n <= 3000 * MS, 1'b1);
		check(horn_o, 1'b0);
		wait_irq(3, n);
		check(n, 3000 * MS);
		check(horn_len, `AMT_HORN_TEST_MS * MS);
		run_mode(AMT_HORN_SMOKE);
		wait_irq(3, n);
		for (int k = 1; k < 6; k++) begin
			check(horn_o, k % 2 == 0);
			wait_irq(3, n);
			check(n, (k == 5 ? 1500 : 500) * MS);
		end
		check(horn_o, 1'b1);
		check(horn_len, 500 * MS);
		run_mode(AMT_HORN_BATTERY);
		wait_irq(3, n);
		check(horn_o, 1'b0);
		wait_irq(3, n);
		check(n, 59750 * MS);
		check(horn_o, 1'b0);
		// The count was loaded with one less than the length at the event and has since dropped once.
		rd_reg(`AMT_OFS_HORN_COUNT, d);
		check(d, `AMT_BATT_OFF_MS * MS - 2);
		@(posedge ref_clk_i);
		#1;
		check(rdata_o, 32'h0);
		wr_reg(`AMT_OFS_CTRL, 32'hf);
		wait_irq(4, n);
		wait_irq(4, n);
		check(n, 250 * MS);
		check(wake_o, 1'b1);
		// Every channel has raised its event by now.
		rd_reg(`AMT_OFS_STATUS, d);
		check(d, 32'h1f);
		// Stop all but the PWM pair, then clear the stopped channels' bits.
		wr_reg(`AMT_OFS_CTRL, 32'h1);
		wr_reg(`AMT_OFS_STATUS, 32'h1c);
		rd_reg(`AMT_OFS_STATUS, d);
		check(d, 32'h3);
		// Stop the PWM pair just after a pulse so no pulse is cut.
		wait_irq(1, n);
		wr_reg(`AMT_OFS_CTRL, 32'h0);
		wr_reg(`AMT_OFS_PWM_PERIOD, 32'h64);
		wr_reg(`AMT_OFS_PWM_DUTY, 32'h5);
		rd_reg(`AMT_OFS_PWM_PERIOD, d);
		check(d, 32'h64);
		rd_reg(`AMT_OFS_PWM_DUTY, d);
		check(d, 32'h5);
		check(pwm_o, 1'b0);
		end_of_test();
	end
endmodule : amt_timer_unit_tb_top
